// ---- design/pdtg_pkg.sv ----
package pdtg_pkg;

	// register map of the parameter register
	localparam logic [15:0] TX_SETTINGS_FIRST_ADDR = 16'h1a04;
	localparam logic [7:0] TX_SETTINGS_FIRST_RESET = 8'h00;
	localparam int ACK_WAIT_BIT = 7;
	localparam int START_KIND_LSB = 4;
	localparam int PERMIT_BIT = 3;
	localparam int MSG_ID_LSB = 0;

	// start-of-packet kinds; 3'h5..3'h7 are reserved
	localparam logic [2:0] SOP_PLAIN = 3'h0;
	localparam logic [2:0] SOP_PRIME = 3'h1;
	localparam logic [2:0] SOP_DPRIME = 3'h2;
	localparam logic [2:0] SOP_PRIME_DEBUG = 3'h3;
	localparam logic [2:0] SOP_DPRIME_DEBUG = 3'h4;
	localparam logic [2:0] SOP_LAST_LEGAL = 3'h4;

	localparam logic [2:0] RETRY_NONE = 3'h0;

	// field order matches the register, bit 7 first
	typedef struct packed {
		logic ackWaitWithoutRetry;
		logic [2:0] txPacketStartKind;
		logic swTransmitPermit;
		logic [2:0] expectedMsgId;
	} pdtg_settings_t;

	// what the receive path reports about an incoming GoodCRC
	typedef struct packed {
		logic valid;
		logic [2:0] sopKind;
		logic [2:0] msgId;
	} pdtg_ack_t;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_SEND = 3'b010,
		ST_WAIT_ACK = 3'b100
	} pdtg_state_t;

endpackage : pdtg_pkg

// ---- design/pdtg_ack_check.sv ----
`timescale 1ns/1ps
module pdtg_ack_check (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire pdtg_pkg::pdtg_ack_t ack,
	input wire logic [2:0] expectedMsgId,
	input wire logic [2:0] expectedStartKind,
	input wire logic checkStartKind,
	output logic ackGood,
	output logic ackBad
);

	logic idMatch;
	logic kindMatch;

	assign idMatch = ack.msgId == expectedMsgId;
	// kind only matters once automatic retry is on
	assign kindMatch = !checkStartKind ||
		ack.sopKind == expectedStartKind;

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			ackGood <= 1'b0;
			ackBad <= 1'b0;
		end else begin
			ackGood <= ack.valid && idMatch && kindMatch;
			ackBad <= ack.valid && !(idMatch && kindMatch);
		end
	end

endmodule : pdtg_ack_check

// ---- design/pdtg_tx_gate.sv ----
`timescale 1ns/1ps
// Overview of operation
// - with no retries and ack-wait set, a sent message awaits GoodCRC.
// - with retries on and auto response on, GoodCRC is always awaited.
// - bits 6:4 pick the start-of-packet kind, codes 5 to 7 reserved.
// - under automatic retry only a GoodCRC of the selected kind is accepted.
// - the permit bit is looked at only when software launches.
// - permit is held low during reset reception or a non-empty rx FIFO.
// - a software launch without permit, alone and while idle, is aborted, never sent.
// - dropping permit never stops a transmission already under way.
// - hardware-made transmissions ignore the permit bit.
// - the link logic reset clears the permit bit.
// - bits 2:0 hold the message ID expected in the GoodCRC.
// - the expected ID is never copied into the outgoing header.
// - a retry limit of zero turns off hardware retransmission.
// - with no retries and no ack-wait, done follows the last bit sent.
module pdtg_tx_gate (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic [15:0] regAddr,
	input wire logic regWrEn,
	input wire logic [7:0] regWrData,
	output logic [7:0] regRdData,
	input wire logic [2:0] retryLimit,
	input wire logic autoResponseEnable,
	input wire logic linkLogicReset,
	input wire logic swLaunch,
	input wire logic hwLaunch,
	input wire logic abortReq,
	input wire logic txPacketSent,
	input wire logic ackTimeout,
	input wire logic rxHardResetSeen,
	input wire logic rxCableResetSeen,
	input wire logic rxFifoNotEmpty,
	input wire pdtg_pkg::pdtg_ack_t ackIn,
	output logic txStart,
	output logic [2:0] txPacketStartKind,
	output logic txBusy,
	output logic txDone,
	output logic txFailed,
	output logic swLaunchAborted,
	output logic startKindReserved
);

	pdtg_pkg::pdtg_settings_t settings;
	pdtg_pkg::pdtg_state_t state;
	pdtg_pkg::pdtg_state_t next_state;
	logic regHit;
	logic permitHold;
	logic autoRetry;
	logic needAck;
	logic launchOk;
	logic ackGood;
	logic ackBad;

	assign regHit = regAddr == pdtg_pkg::TX_SETTINGS_FIRST_ADDR;
	assign permitHold = rxHardResetSeen || rxCableResetSeen ||
		rxFifoNotEmpty;
	assign autoRetry = retryLimit != pdtg_pkg::RETRY_NONE &&
		autoResponseEnable;
	// retries on without auto response: fall back to the ack-wait bit
	assign needAck = autoRetry ||
		settings.ackWaitWithoutRetry;

	// register; expected ID stays local and never reaches a header
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			settings <= pdtg_pkg::TX_SETTINGS_FIRST_RESET;
		end else begin
			if (regWrEn && regHit) begin
				settings <= regWrData;
			end
			// hold wins over a software write of one
			if (permitHold || linkLogicReset) begin
				settings.swTransmitPermit <= 1'b0;
			end
		end
	end

	assign regRdData = regHit ? settings : 8'h00;
	assign txPacketStartKind = settings.txPacketStartKind;
	assign startKindReserved =
		settings.txPacketStartKind > pdtg_pkg::SOP_LAST_LEGAL;

	pdtg_ack_check u_ack (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.ack(ackIn),
		.expectedMsgId(settings.expectedMsgId),
		.expectedStartKind(settings.txPacketStartKind),
		.checkStartKind(autoRetry),
		.ackGood(ackGood),
		.ackBad(ackBad)
	);

	// hardware launches skip the permit; software needs it at the launch
	assign launchOk = hwLaunch ||
		(swLaunch && settings.swTransmitPermit);

	always_comb begin
		next_state = state;
		unique case (state)
			pdtg_pkg::ST_IDLE: begin
				if (launchOk) begin
					next_state = pdtg_pkg::ST_SEND;
				end
			end
			pdtg_pkg::ST_SEND: begin
				if (abortReq) begin
					next_state = pdtg_pkg::ST_IDLE;
				end else if (txPacketSent) begin
					next_state = needAck ? pdtg_pkg::ST_WAIT_ACK :
						pdtg_pkg::ST_IDLE;
				end
			end
			pdtg_pkg::ST_WAIT_ACK: begin
				if (abortReq || ackGood || ackTimeout) begin
					next_state = pdtg_pkg::ST_IDLE;
				end
			end
			default: begin
				next_state = pdtg_pkg::ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n || linkLogicReset) begin
			state <= pdtg_pkg::ST_IDLE;
		end else begin
			state <= next_state;
		end
	end

	assign txBusy = state != pdtg_pkg::ST_IDLE;
	assign txStart = state == pdtg_pkg::ST_IDLE && launchOk &&
		!linkLogicReset;

	// completion and abort pulses
	always_ff @(posedge clk_sys) begin
		if (!rst_n || linkLogicReset) begin
			txDone <= 1'b0;
			txFailed <= 1'b0;
			swLaunchAborted <= 1'b0;
		end else begin
			txDone <= (state == pdtg_pkg::ST_SEND && txPacketSent &&
				!abortReq && !needAck) ||
				(state == pdtg_pkg::ST_WAIT_ACK && ackGood &&
				!abortReq);
			txFailed <= (txBusy && abortReq) ||
				(state == pdtg_pkg::ST_WAIT_ACK && ackTimeout &&
				!ackGood && !abortReq);
			swLaunchAborted <= state == pdtg_pkg::ST_IDLE && swLaunch &&
				!hwLaunch && !settings.swTransmitPermit;
		end
	end

	// ackBad is only observed; a mismatched reply keeps the wait going
	logic unusedBad;
	assign unusedBad = ackBad;

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	permit_hold_a: assert property (permitHold |=>
		!settings.swTransmitPermit)
		else $error("permit not held low during rx activity");
	link_reset_a: assert property (linkLogicReset |=>
		!settings.swTransmitPermit && !txBusy)
		else $error("link reset did not clear permit");
	sw_abort_a: assert property (!txBusy && swLaunch && !hwLaunch &&
		!settings.swTransmitPermit && !linkLogicReset |=>
		swLaunchAborted && !txBusy)
		else $error("unpermitted launch was not aborted");
	hw_launch_a: assert property (!txBusy && hwLaunch &&
		!linkLogicReset |-> txStart ##1 txBusy)
		else $error("hardware launch blocked");
	permit_late_a: assert property (state == pdtg_pkg::ST_SEND &&
		!abortReq && !txPacketSent && !linkLogicReset &&
		$fell(settings.swTransmitPermit) |=> txBusy)
		else $error("permit drop stopped a transmission");
	ack_wait_a: assert property (state == pdtg_pkg::ST_SEND &&
		txPacketSent && !abortReq && !linkLogicReset && needAck |=>
		state == pdtg_pkg::ST_WAIT_ACK && !txDone)
		else $error("ack wait skipped");
	auto_wait_a: assert property (
		state == pdtg_pkg::ST_SEND && txPacketSent && !abortReq &&
		!linkLogicReset && autoRetry && !settings.ackWaitWithoutRetry |=>
		state == pdtg_pkg::ST_WAIT_ACK)
		else $error("auto retry without ack wait");
	no_wait_a: assert property (state == pdtg_pkg::ST_SEND &&
		txPacketSent && !abortReq && !linkLogicReset && !needAck |=>
		txDone && !txBusy)
		else $error("done late without ack wait");
	kind_check_a: assert property (state == pdtg_pkg::ST_WAIT_ACK &&
		ackIn.valid && autoRetry &&
		ackIn.sopKind != settings.txPacketStartKind |=> !ackGood)
		else $error("wrong start kind accepted");
	id_check_a: assert property (ackIn.valid &&
		ackIn.msgId != settings.expectedMsgId |=> !ackGood)
		else $error("wrong message id accepted");
	reset_zero_a: assert property ($rose(rst_n) |->
		8'(settings) == pdtg_pkg::TX_SETTINGS_FIRST_RESET)
		else $error("register not zero after reset");

	// transmit path endings
	abort_send_a: assert property (
		state == pdtg_pkg::ST_SEND && abortReq && !linkLogicReset |=>
		!txBusy && txFailed && !txDone)
		else $error("abort did not end sending");
	abort_wait_a: assert property (
		state == pdtg_pkg::ST_WAIT_ACK && abortReq && !linkLogicReset |=>
		!txBusy && txFailed && !txDone)
		else $error("abort did not end ack wait");
	ack_done_a: assert property (
		state == pdtg_pkg::ST_WAIT_ACK && ackGood && !abortReq &&
		!linkLogicReset |=> txDone && !txFailed && !txBusy)
		else $error("accepted reply did not finish");
	timeout_fail_a: assert property (
		state == pdtg_pkg::ST_WAIT_ACK && ackTimeout && !ackGood &&
		!abortReq && !linkLogicReset |=> txFailed && !txDone && !txBusy)
		else $error("timeout did not fail the wait");
	bad_ack_a: assert property (
		state == pdtg_pkg::ST_WAIT_ACK && ackBad && !ackTimeout &&
		!abortReq && !linkLogicReset |=> state == pdtg_pkg::ST_WAIT_ACK)
		else $error("mismatched reply ended the wait");
	abort_idle_a: assert property (state == pdtg_pkg::ST_IDLE &&
		abortReq |=> !txFailed)
		else $error("abort while idle reported a failure");

	// state holding
	send_hold_a: assert property (
		state == pdtg_pkg::ST_SEND && !abortReq && !txPacketSent &&
		!linkLogicReset |=> state == pdtg_pkg::ST_SEND)
		else $error("sending left without cause");
	wait_hold_a: assert property (
		state == pdtg_pkg::ST_WAIT_ACK && !abortReq && !ackGood &&
		!ackTimeout && !linkLogicReset |=> state == pdtg_pkg::ST_WAIT_ACK)
		else $error("ack wait left without cause");
	idle_quiet_a: assert property (state == pdtg_pkg::ST_IDLE &&
		!launchOk |=> !txBusy)
		else $error("busy without a launch");
	done_busy_a: assert property (txDone |-> $past(txBusy))
		else $error("done pulse from idle");
	failed_busy_a: assert property (txFailed |-> $past(txBusy))
		else $error("failed pulse from idle");
	pulse_excl_a: assert property (!(txDone && txFailed))
		else $error("done and failed together");
	one_state_a: assert property ($onehot(state))
		else $error("state code not one-hot");

	// reply checking
	good_ack_a: assert property (
		ackIn.valid && ackIn.msgId == settings.expectedMsgId &&
		(!autoRetry || ackIn.sopKind == settings.txPacketStartKind) |=>
		ackGood && !ackBad)
		else $error("matching reply rejected");
	kind_free_a: assert property (
		ackIn.valid && !autoRetry &&
		ackIn.msgId == settings.expectedMsgId &&
		ackIn.sopKind != settings.txPacketStartKind |=> ackGood)
		else $error("kind checked with retries off");
	no_reply_a: assert property (!ackIn.valid |=> !ackGood && !ackBad)
		else $error("reply flagged without valid");

	// register port
	write_land_a: assert property (regWrEn && regHit && !permitHold &&
		!linkLogicReset |=> 8'(settings) == $past(regWrData))
		else $error("register write lost");
	write_hold_a: assert property (
		regWrEn && regHit && (permitHold || linkLogicReset) |=>
		8'(settings) == ($past(regWrData) & 8'hf7))
		else $error("held permit bit was written");
	reserved_keep_a: assert property (
		regWrEn && regHit &&
		regWrData[6:4] > pdtg_pkg::SOP_LAST_LEGAL |=> startKindReserved)
		else $error("reserved kind not flagged");
	other_addr_a: assert property (!regHit |-> regRdData == 8'h00)
		else $error("unmapped address read non-zero");

	// launch gating
	sw_start_a: assert property (
		!txBusy && swLaunch && settings.swTransmitPermit &&
		!linkLogicReset |-> txStart ##1 txBusy)
		else $error("permitted software launch refused");
	busy_ignore_a: assert property (txBusy && (swLaunch || hwLaunch) |->
		!txStart)
		else $error("launch accepted while busy");
	hw_no_abort_a: assert property (hwLaunch |=> !swLaunchAborted)
		else $error("hardware launch reported as aborted");
	link_quiet_a: assert property (
		linkLogicReset |-> !txStart ##1 (!txDone && !txFailed &&
		!swLaunchAborted))
		else $error("link reset left a pulse");

	sw_send_c: cover property (swLaunch && settings.swTransmitPermit &&
		!txBusy ##[1:20] txDone);
	ack_done_c: cover property (state == pdtg_pkg::ST_WAIT_ACK && ackGood);
	sw_abort_c: cover property (swLaunchAborted);
	hold_c: cover property (permitHold && regWrEn && regHit);
	timeout_c: cover property (state == pdtg_pkg::ST_WAIT_ACK && ackTimeout);

endmodule : pdtg_tx_gate

// ---- test/pdtg_remote_port.sv ----
`timescale 1ns/1ps
module pdtg_remote_port (
	input wire logic clk_sys,
	input wire logic txStart,
	input wire logic reply,
	input wire logic [2:0] replyKind,
	input wire logic [2:0] replyId,
	input wire logic [3:0] delay,
	output logic txPacketSent,
	output pdtg_pkg::pdtg_ack_t ackIn
);
	initial begin
		txPacketSent = 1'b0;
		ackIn = '0;
		forever begin
			@(posedge clk_sys);
			if (txStart === 1'b1) begin
				repeat (delay) @(negedge clk_sys);
				txPacketSent = 1'b1;
				@(negedge clk_sys);
				txPacketSent = 1'b0;
				if (reply) begin
					repeat (delay) @(negedge clk_sys);
					// kind and id as driven on replyKind and replyId by the test
					ackIn = {1'b1, replyKind, replyId};
					@(negedge clk_sys);
					// fields are not held once valid drops
					ackIn = {1'b0, ~replyKind, ~replyId};
				end
			end
		end
	end
endmodule : pdtg_remote_port

// ---- test/test_pd_tx_param_goodcrc_gate.sv ----
`timescale 1ns/1ps
`define CHK(nm, e, g) begin numChecks++; if ((g) !== (e)) begin errorCnt++; \
$display("mismatch %s exp %h got %h", nm, e, g); end end
module test_pd_tx_param_goodcrc_gate;
	localparam logic [15:0] A = pdtg_pkg::TX_SETTINGS_FIRST_ADDR;
	logic clk_sys, rst_n, regWrEn, autoResponseEnable, linkLogicReset;
	logic swLaunch, hwLaunch, abortReq, txPacketSent, ackTimeout, reply;
	logic rxFifoNotEmpty, txStart, txBusy, txDone, txFailed, swLaunchAborted;
	logic startKindReserved;
	logic [15:0] regAddr;
	logic [7:0] regWrData, regRdData;
	logic [2:0] retryLimit, txPacketStartKind, replyKind, id, e;
	logic [3:0] delay;
	logic [31:0] rng;
	pdtg_pkg::pdtg_ack_t ackIn;
	logic [2:0] q[$];
	int errorCnt = 0;
	int numChecks = 0;
	pdtg_tx_gate pdtg_tx_gate_i (.clk_sys(clk_sys), .rst_n(rst_n),
		.regAddr(regAddr), .regWrEn(regWrEn), .regWrData(regWrData),
		.regRdData(regRdData), .retryLimit(retryLimit),
		.autoResponseEnable(autoResponseEnable),
		.linkLogicReset(linkLogicReset), .swLaunch(swLaunch),
		.hwLaunch(hwLaunch), .abortReq(abortReq), .txPacketSent(txPacketSent),
		.ackTimeout(ackTimeout), .rxHardResetSeen(1'b0),
		.rxCableResetSeen(1'b0), .rxFifoNotEmpty(rxFifoNotEmpty),
		.ackIn(ackIn), .txStart(txStart),
		.txPacketStartKind(txPacketStartKind), .txBusy(txBusy),
		.txDone(txDone), .txFailed(txFailed),
		.swLaunchAborted(swLaunchAborted),
		.startKindReserved(startKindReserved));
	pdtg_remote_port pdtg_remote_port_i (.clk_sys(clk_sys), .txStart(txStart),
		.reply(reply), .replyKind(replyKind), .replyId(id), .delay(delay),
		.txPacketSent(txPacketSent), .ackIn(ackIn));
	initial begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end
	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction : xs
	task endOfTest;
		if (errorCnt == 0 && numChecks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : endOfTest
	task wr(input logic [7:0] d);
		@(negedge clk_sys);
		regAddr = A;
		regWrData = d;
		regWrEn = 1'b1;
		@(negedge clk_sys);
		regWrEn = 1'b0;
	endtask : wr
	task rdChk(input logic [15:0] a, input logic [7:0] x);
		@(negedge clk_sys);
		regAddr = a;
		#1 `CHK("regRdData", x, regRdData)
	endtask : rdChk
	task go(input logic hw, input logic [2:0] x);
		q.push_back(x);
		rng = xs(rng);
		delay = {2'b00, rng[1:0]} + 4'h1;
		@(negedge clk_sys);
		hwLaunch = hw;
		swLaunch = ~hw;
		#1 `CHK("txStart", x != 3'b001, txStart)
		@(negedge clk_sys);
		`CHK("txBusy", x != 3'b001, txBusy)
		hwLaunch = 1'b0;
		swLaunch = 1'b0;
	endtask : go
	task waitRes;
		for (int i = 0; i < 60 && q.size() != 0; i++) @(negedge clk_sys);
		if (q.size() != 0) begin
			errorCnt++;
			endOfTest;
		end
	endtask : waitRes
	// results come as {done, failed, aborted}, oldest note first
	always @(negedge clk_sys) begin
		if (rst_n === 1'b1 &&
			{txDone, txFailed, swLaunchAborted} !== 3'b000) begin
			e = (q.size() != 0) ? q.pop_front() : 3'b000;
			`CHK("result", e, {txDone, txFailed, swLaunchAborted})
		end
	end
	initial begin
		{rst_n, regWrEn, autoResponseEnable, linkLogicReset, swLaunch} = '0;
		{hwLaunch, abortReq, ackTimeout, reply, rxFifoNotEmpty} = '0;
		{regAddr, regWrData, retryLimit, replyKind, id, delay} = '0;
		rng = 32'h17c53a19;
		repeat (10) @(negedge clk_sys);
		rst_n = 1'b1;
		rdChk(A, 8'h00);
		for (int k = 0; k < 8; k++) begin
			wr({1'b0, k[2:0], 4'h0});
			`CHK("kind", k[2:0], txPacketStartKind)
			`CHK("reserved", k > 4, startKindReserved)
		end
		rdChk(16'h1a05, 8'h00);
		wr(8'h00);
		go(1'b0, 3'b001);
		waitRes;
		rxFifoNotEmpty = 1'b1;
		wr(8'h08);
		rdChk(A, 8'h00);
		rxFifoNotEmpty = 1'b0;
		wr(8'h08);
		go(1'b0, 3'b100);
		wr(8'h00); // permit dropped just after the send has ended
		waitRes;
		rng = xs(rng);
		id = rng[2:0];
		reply = 1'b1;
		replyKind = 3'h3;
		wr({1'b1, 3'h0, 1'b0, id});
		go(1'b1, 3'b100);
		waitRes;
		retryLimit = 3'h3;
		autoResponseEnable = 1'b1;
		for (int j = 0; j < 2; j++) begin
			replyKind = j ? 3'h2 : 3'h1;
			wr({1'b0, 3'h2, 1'b1, id});
			go(1'b0, j ? 3'b100 : 3'b010);
			if (j == 0) begin
				repeat (14) @(negedge clk_sys);
				ackTimeout = 1'b1;
				@(negedge clk_sys);
				ackTimeout = 1'b0;
			end
			waitRes;
		end
		reply = 1'b0;
		go(1'b1, 3'b010);
		@(negedge clk_sys);
		abortReq = 1'b1;
		@(negedge clk_sys);
		abortReq = 1'b0;
		waitRes;
		wr(8'h3d);
		linkLogicReset = 1'b1;
		@(negedge clk_sys);
		linkLogicReset = 1'b0;
		rdChk(A, 8'h35);
		wr(8'h30); // software zeroes the expected id after a reset
		rdChk(A, 8'h30);
		repeat (5) @(negedge clk_sys);
		endOfTest;
	end
endmodule : test_pd_tx_param_goodcrc_gate
